// [rtl/i2c_port_consts.svh]
// Constants of the two-wire register port
`ifndef I2C_PORT_CONSTS_SVH
`define I2C_PORT_CONSTS_SVH
`define TARGET_ADDR        7'h66
`define REG_COUNT          3'h6
`define RST_CONFIG         8'h01
`define RST_OSC            8'h00
`define RST_HAPTIC_A       8'h0a
`define RST_HAPTIC_B       8'h85
`define RST_LDOH           8'h00
`define RST_LDOV           8'h1a
`define IDX_CONFIG         3'h0
`define IDX_OSC            3'h1
`define IDX_HAPTIC_A       3'h2
`define IDX_HAPTIC_B       3'h3
`define IDX_LDOH           3'h4
`define IDX_LDOV           3'h5
`define MAX_BIT_RATE_KBPS  400
`endif

// [rtl/i2c_port_pkg.sv]
// Types shared by the two-wire register port
`default_nettype none
package i2c_port_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] reg_idx_t;
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_ACK,
    ST_RACK,
    ST_IGNORE
  } port_state_t;
endpackage : i2c_port_pkg
`default_nettype wire

// [rtl/line_sync.sv]
// Two-flop synchroniser with edge detection for one bus line
`default_nettype none
module line_sync
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_in,
  // Line
  input  wire logic line_in,
  // Synchronised level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_prev;

  always_comb
  begin
    nxt_meta = line_in;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  // Lines rest high, so reset to the released level
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  assign level_out = sync_ff;
  assign rise_out  = sync_ff & ~prev_ff;
  assign fall_out  = ~sync_ff & prev_ff;
endmodule : line_sync
`default_nettype wire

// [rtl/i2c_reg_port.sv]
// Two-wire serial target port holding six 8-bit configuration registers
// Behaviour
// - Six registers are stored and each can be written and read back over the bus.
// - The port samples the lines fast enough to work at bus rates up to 400 kbit/s.
// - The data line is released whenever no transfer is in progress, so both lines rest high.
// - The port never starts a transfer and only answers bytes addressed to it.
// - Only the fixed 7-bit address 1100110 is answered.
// - The address is received MSB first, followed by a direction bit, 0 write and 1 read.
// - The pointer and data are whole 8-bit bytes.
// - A write is start, address+W, ack, pointer, ack, data, ack, stop.
// - A read is pointer write, repeated start, address+R, ack, one data byte, master nack, stop.
// - Address, pointer and the first written data byte are acknowledged by pulling data low; later data bytes are not.
`include "i2c_port_consts.svh"
`default_nettype none
module i2c_reg_port
(
  // Clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  // Bus lines
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_out,
  // Register contents
  output i2c_port_pkg::byte_t       config_out,
  output i2c_port_pkg::byte_t       osc_out,
  output i2c_port_pkg::byte_t       haptic_a_out,
  output i2c_port_pkg::byte_t       haptic_b_out,
  output i2c_port_pkg::byte_t       ldoh_out,
  output i2c_port_pkg::byte_t       ldov_out,
  // Transfer activity
  output logic                      busy_out
);
  import i2c_port_pkg::*;

  logic        scl_lvl;
  logic        scl_rise;
  logic        scl_fall;
  logic        sda_lvl;
  logic        sda_rise;
  logic        sda_fall;

  port_state_t state_ff;
  port_state_t nxt_state;
  // Where the transfer goes once the ack clock ends
  port_state_t after_ack_ff;
  port_state_t nxt_after_ack;
  byte_t       shift_ff;
  byte_t       nxt_shift;
  logic [3:0]  bit_cnt_ff;
  logic [3:0]  nxt_bit_cnt;
  reg_idx_t    ptr_ff;
  reg_idx_t    nxt_ptr;
  logic        ptr_ok_ff;
  logic        nxt_ptr_ok;
  logic        drive_low_ff;
  logic        nxt_drive_low;
  logic        busy_ff;
  logic        nxt_busy;
  byte_t       regs_ff [0:5];
  byte_t       nxt_regs [0:5];
  // One-cycle strobe from the transfer logic into the register file
  logic        reg_wr;

  // 200 MHz sampling gives over 60 samples per 400 kbit/s bit
  line_sync u_scl_sync
  (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .line_in   (scl_in),
    .level_out (scl_lvl),
    .rise_out  (scl_rise),
    .fall_out  (scl_fall)
  );
  line_sync u_sda_sync
  (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .line_in   (sda_in),
    .level_out (sda_lvl),
    .rise_out  (sda_rise),
    .fall_out  (sda_fall)
  );

  function automatic byte_t reset_value(input reg_idx_t idx);
    unique case (idx)
      `IDX_CONFIG:   reset_value = `RST_CONFIG;
      `IDX_OSC:      reset_value = `RST_OSC;
      `IDX_HAPTIC_A: reset_value = `RST_HAPTIC_A;
      `IDX_HAPTIC_B: reset_value = `RST_HAPTIC_B;
      `IDX_LDOH:     reset_value = `RST_LDOH;
      default:       reset_value = `RST_LDOV;
    endcase
  endfunction : reset_value

  // Level for the next read bit on the data line: pull low for a zero
  function automatic logic read_pull(input byte_t data, input logic [3:0] sent);
    read_pull = ~data[3'h7 - sent[2:0]];
  endfunction : read_pull

  // Both lines share one synchroniser depth, so their edges stay in order
  logic start_cond;
  logic stop_cond;
  assign start_cond = scl_lvl & sda_fall;
  assign stop_cond  = scl_lvl & sda_rise;

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_after_ack = after_ack_ff;
    nxt_shift     = shift_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_ptr       = ptr_ff;
    nxt_ptr_ok    = ptr_ok_ff;
    nxt_drive_low = drive_low_ff;
    nxt_busy      = busy_ff;
    reg_wr        = 1'b0;
    if (start_cond)
    begin
      // Repeated start restarts address reception, pointer kept
      nxt_state     = ST_ADDR;
      nxt_bit_cnt   = 4'h0;
      nxt_drive_low = 1'b0;
      nxt_busy      = 1'b1;
    end
    else if (stop_cond)
    begin
      nxt_state     = ST_IDLE;
      nxt_drive_low = 1'b0;
      nxt_busy      = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE, ST_IGNORE:
        begin
          nxt_drive_low = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            nxt_shift   = {shift_ff[6:0], sda_lvl};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
          else if (scl_fall && bit_cnt_ff == 4'h8)
          begin
            nxt_bit_cnt = 4'h0;
            if (state_ff == ST_ADDR)
            begin
              if (shift_ff[7:1] != `TARGET_ADDR)
              begin
                // Stay off the line until the next start or stop
                nxt_state = ST_IGNORE;
              end
              else
              begin
                nxt_drive_low = 1'b1;
                nxt_state     = ST_ACK;
                nxt_after_ack = shift_ff[0] ? ST_RDATA : ST_PTR;
                if (shift_ff[0])
                begin
                  nxt_shift = ptr_ok_ff ? regs_ff[ptr_ff] : 8'h00;
                end
              end
            end
            else if (state_ff == ST_PTR)
            begin
              nxt_ptr       = shift_ff[2:0];
              nxt_ptr_ok    = shift_ff < {5'h00, `REG_COUNT};
              nxt_drive_low = 1'b1;
              nxt_state     = ST_ACK;
              nxt_after_ack = ST_WDATA;
            end
            else
            begin
              // Writes to pointers past the last register are acked but dropped
              reg_wr        = ptr_ok_ff;
              nxt_drive_low = 1'b1;
              nxt_state     = ST_ACK;
              nxt_after_ack = ST_IGNORE;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            nxt_state = after_ack_ff;
            if (after_ack_ff == ST_RDATA)
            begin
              // First read bit goes out as the ack clock ends
              nxt_drive_low = read_pull(shift_ff, 4'h0);
              nxt_bit_cnt   = 4'h1;
            end
            else
            begin
              nxt_drive_low = 1'b0;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_ff == 4'h8)
            begin
              nxt_drive_low = 1'b0;
              nxt_state     = ST_RACK;
            end
            else
            begin
              nxt_drive_low = read_pull(shift_ff, bit_cnt_ff);
              nxt_bit_cnt   = bit_cnt_ff + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          // Single byte read; later clocks are ignored whatever the master answers
          if (scl_fall)
          begin
            nxt_state = ST_IGNORE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state_ff     <= ST_IDLE;
      after_ack_ff <= ST_IDLE;
      shift_ff     <= 8'h00;
      bit_cnt_ff   <= 4'h0;
      ptr_ff       <= 3'h0;
      // Pointer starts at the first register, so the first read is defined
      ptr_ok_ff    <= 1'b1;
      drive_low_ff <= 1'b0;
      busy_ff      <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      after_ack_ff <= nxt_after_ack;
      shift_ff     <= nxt_shift;
      bit_cnt_ff   <= nxt_bit_cnt;
      ptr_ff       <= nxt_ptr;
      ptr_ok_ff    <= nxt_ptr_ok;
      drive_low_ff <= nxt_drive_low;
      busy_ff      <= nxt_busy;
    end
  end

  // Register file: one write strobe, so the six bytes never see a partial update
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      nxt_regs[i] = regs_ff[i];
    end
    if (reg_wr)
    begin
      nxt_regs[ptr_ff] = shift_ff;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < 6; i++)
      begin
        regs_ff[i] <= reset_value(3'(i));
      end
    end
    else
    begin
      for (int i = 0; i < 6; i++)
      begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // Open drain: only ever pull low, never drive high
  assign sda_out      = 1'b0;
  assign sda_oe_out   = drive_low_ff;
  assign config_out   = regs_ff[`IDX_CONFIG];
  assign osc_out      = regs_ff[`IDX_OSC];
  assign haptic_a_out = regs_ff[`IDX_HAPTIC_A];
  assign haptic_b_out = regs_ff[`IDX_HAPTIC_B];
  assign ldoh_out     = regs_ff[`IDX_LDOH];
  assign ldov_out     = regs_ff[`IDX_LDOV];
  assign busy_out     = busy_ff;
endmodule : i2c_reg_port
`default_nettype wire

// [sim/i2c_reg_port_assertions.sv]
// Port assertions of the two-wire register port
`default_nettype none
module i2c_reg_port_assertions
(
  // Clock, reset and bus lines
  input wire logic                mclk_in,
  input wire logic                reset_in,
  input wire logic                scl_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe_out,
  // Registers and activity
  input wire i2c_port_pkg::byte_t config_out,
  input wire i2c_port_pkg::byte_t osc_out,
  input wire i2c_port_pkg::byte_t haptic_a_out,
  input wire i2c_port_pkg::byte_t haptic_b_out,
  input wire i2c_port_pkg::byte_t ldoh_out,
  input wire i2c_port_pkg::byte_t ldov_out,
  input wire logic                busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_port_pkg::*;
  wire logic [47:0] regs = {ldov_out, ldoh_out, haptic_b_out, haptic_a_out, osc_out, config_out};
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  a_reset_values: assert property (disable iff (1'b0)
    reset_in |=> regs == 48'h1a00850a0001 && !busy_out && !sda_oe_out)
    else $error("reset state wrong");
  a_pull_only: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_idle_release: assert property (!busy_out |-> !sda_oe_out)
    else $error("data pulled while idle");
  a_regs_idle: assert property (!busy_out |=> $stable(regs))
    else $error("register changed while idle");
  a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data changed with clock high");
  a_ack_holds: assert property ($rose(scl_in) && sda_oe_out |-> sda_oe_out [*8])
    else $error("pull dropped in clock high");
  a_busy_start: assert property ($rose(busy_out) |-> scl_in && !sda_in)
    else $error("busy without start");
  a_busy_stop: assert property ($fell(busy_out) |-> scl_in && sda_in)
    else $error("busy ended without stop");
  c_stop: cover property ($fell(busy_out));
  c_ack: cover property ($rose(scl_in) && sda_oe_out);
  c_write: cover property ($changed(haptic_b_out));
endmodule : i2c_reg_port_assertions
bind i2c_reg_port i2c_reg_port_assertions i_i2c_reg_port_assertions
(
  .mclk_in      (mclk_in),
  .reset_in     (reset_in),
  .scl_in       (scl_in),
  .sda_in       (sda_in),
  .sda_out      (sda_out),
  .sda_oe_out   (sda_oe_out),
  .config_out   (config_out),
  .osc_out      (osc_out),
  .haptic_a_out (haptic_a_out),
  .haptic_b_out (haptic_b_out),
  .ldoh_out     (ldoh_out),
  .ldov_out     (ldov_out),
  .busy_out     (busy_out)
);
`default_nettype wire

// [sim/i2c_master_model.sv]
// Bus master model for the two-wire register port
`default_nettype none
module i2c_master_model
(
  // Clock and sensed data line
  input  wire logic mclk_in,
  input  wire logic sda_in,
  // Open drain lines, 1 releases
  output var logic  scl_out,
  output var logic  sda_drv_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_port_pkg::*;
  // Both lines released from the start, so the bus rests high
  initial
  begin
    scl_out     = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic q();
    repeat (8) @(negedge mclk_in);
  endtask : q
  task automatic ph(input logic c, input logic d);
    scl_out = c;
    sda_drv_out = d;
    q();
  endtask : ph
  // Data rises while the clock is low, so this also serves as repeated start
  task automatic start();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask : stop
  // Ninth bit always released: reads the ack, or sends the nack after a read
  task automatic xfer(input byte_t d, output byte_t r, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      ph(1'b0, i > 0 ? d[i-1] : 1'b1);
      ph(1'b1, sda_drv_out);
      if (i > 0)
        r[i-1] = sda_in;
      else
        ack = sda_in;
      ph(1'b1, sda_drv_out);
      ph(1'b0, sda_drv_out);
    end
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// [sim/i2c_reg_port_tb.sv]
// Self-checking bench of the two-wire register port
`include "i2c_port_consts.svh"
`default_nettype none
module i2c_reg_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_port_pkg::*;
  localparam byte_t AW = {`TARGET_ADDR, 1'b0};
  localparam byte_t AR = {`TARGET_ADDR, 1'b1};
  byte_t dflt [6] = '{`RST_CONFIG, `RST_OSC, `RST_HAPTIC_A, `RST_HAPTIC_B, `RST_LDOH, `RST_LDOV};
  byte_t exp_r [6];
  logic  mclk = 1'b0;
  logic  reset = 1'b1;
  int    mismatches = 0;
  int    cmp_count = 0;
  wire logic  scl, sda_m, sda_o, sda_oe, busy;
  wire byte_t cfg, osc, ha, hb, lh, lv;
  wire logic  sda = sda_m & (sda_oe ? sda_o : 1'b1);
  wire logic [47:0] regs = {lv, lh, hb, ha, osc, cfg};
  i2c_reg_port i_i2c_reg_port (.mclk_in(mclk), .reset_in(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .config_out(cfg), .osc_out(osc), .haptic_a_out(ha),
    .haptic_b_out(hb), .ldoh_out(lh), .ldov_out(lv), .busy_out(busy));
  i2c_master_model i_i2c_master_model (.mclk_in(mclk), .sda_in(sda), .scl_out(scl),
    .sda_drv_out(sda_m));
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input byte_t exp, input byte_t got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tx(input byte_t d, input logic ack);
    byte_t r;
    logic  a;
    i_i2c_master_model.xfer(d, r, a);
    chk("ack bit", byte_t'(ack), byte_t'(a));
  endtask : tx
  task automatic fin();
    i_i2c_master_model.stop();
    i_i2c_master_model.q();
    chk("busy", 8'h00, byte_t'(busy));
    chk("idle data", 8'h01, byte_t'(sda));
  endtask : fin
  task automatic wr(input byte_t p, input byte_t d);
    i_i2c_master_model.start();
    tx(AW, 1'b0);
    tx(p, 1'b0);
    tx(d, 1'b0);
    fin();
    if (p < 8'h06)
      exp_r[p[2:0]] = d;
  endtask : wr
  task automatic rd(input byte_t p, output byte_t d);
    logic a;
    i_i2c_master_model.start();
    tx(AW, 1'b0);
    tx(p, 1'b0);
    i_i2c_master_model.start();
    tx(AR, 1'b0);
    i_i2c_master_model.xfer(8'hff, d, a);
    fin();
  endtask : rd
  task automatic check_all();
    for (int i = 0; i < 6; i++)
      chk("register", exp_r[i], regs[i*8 +: 8]);
  endtask : check_all
  task automatic t_defaults();
    byte_t d;
    exp_r = dflt;
    check_all();
    for (int i = 0; i < 6; i++)
    begin
      rd(byte_t'(i), d);
      chk("read default", dflt[i], d);
    end
    $display("done defaults");
  endtask : t_defaults
  // All writes before any read, so an index that aliases shows up
  task automatic t_write_read();
    byte_t d;
    for (int i = 0; i < 6; i++)
      wr(byte_t'(i), 8'h5a ^ byte_t'(i));
    check_all();
    for (int i = 0; i < 6; i++)
    begin
      rd(byte_t'(i), d);
      chk("read back", exp_r[i], d);
    end
    $display("done write_read");
  endtask : t_write_read
  task automatic t_foreign();
    byte_t bad [2] = '{8'hce, 8'h4c};
    for (int i = 0; i < 2; i++)
    begin
      i_i2c_master_model.start();
      tx(bad[i], 1'b1);
      tx(8'h01, 1'b1);
      tx(8'hee, 1'b1);
      fin();
    end
    check_all();
    $display("done foreign");
  endtask : t_foreign
  task automatic t_extra_range();
    byte_t d;
    i_i2c_master_model.start();
    tx(AW, 1'b0);
    tx(8'h02, 1'b0);
    tx(8'h3c, 1'b0);
    tx(8'hc3, 1'b1);
    fin();
    exp_r[2] = 8'h3c;
    wr(8'h06, 8'h77);
    check_all();
    rd(8'h06, d);
    chk("read past six", 8'h00, d);
    $display("done extra_range");
  endtask : t_extra_range
  task automatic t_reset_mid();
    byte_t d;
    i_i2c_master_model.start();
    tx(AW, 1'b0);
    tx(8'h05, 1'b0);
    reset = 1'b1;
    i_i2c_master_model.q();
    chk("busy in reset", 8'h00, byte_t'(busy));
    chk("data in reset", 8'h01, byte_t'(sda));
    exp_r = dflt;
    check_all();
    reset = 1'b0;
    fin();
    // The port must answer normally once the cut transfer is closed
    rd(8'h00, d);
    chk("read after reset", dflt[0], d);
    $display("done reset_mid");
  endtask : t_reset_mid
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial
  begin
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    i_i2c_master_model.q();
    t_defaults();
    t_write_read();
    t_foreign();
    t_extra_range();
    t_reset_mid();
    results();
  end
endmodule : i2c_reg_port_tb
`default_nettype wire
